// [design/dpm_power_manager.sv]
// Behaviour
// - Standby starts panel power-off, stops video clock, blanks display.
// - Standby memory sequencer serves only refresh and host; host keeps memory and I/O, DAC is powered down.
// - Standby driven by pins, register bits, memory and keyboard activity.
// - Dual display: standby or suspend also turns monitor signalling fully off.
// - Suspend: panel off, memory and video clock off, host memory refused, DAC down.
// - Register-caused suspend keeps every register reachable by software.
// - Pin-caused suspend powers down host interface; only pin path ends it.
// - Suspend pin release acts at once, never delayed by the timer.
// - Control and timer registers readable and writable for save and restore; status and strap are read only.
// - Standby while any enabled source is active, ends when all are idle.
// - Pin suspend ends on pin release or pin disable; register suspend on clear.
// - Power state table for software suspend, hardware suspend and off.
// - A register bit chooses backlight output polarity.
// - Panel up: logic power, +1 frame interface, +3 bias, +1 backlight.
// - Panel down: backlight off, +1 bias off, +3 interface off, +1 logic off.
// - Sync and DAC enables follow the monitor power saving table per state.
// - Capture data, capture vsync and GPIO 0..11 latched when reset releases.
// - Timer watches a selectable mix of pin, memory and keyboard activity.
// - Timer period is half a minute or 1 to 15 whole minutes.
// - No activity for the whole period sets a readable time-out status.
// - Activity select 000 clears the time-out state.
// - For standby or monitor saving, activity also clears the time-out.
`timescale 1ns/1ps
`default_nettype none
module dpm_power_manager #(
  parameter logic [31:0] HALF_MIN_CYCLES = dpm_pkg::HALF_MIN_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Power request pins, asynchronous
  input wire logic standby_pin_in,
  input wire logic suspend_pin_in,
  input wire logic activity_pin_in,
  // Activity events from the memory and keyboard paths
  input wire logic mem_access_in,
  input wire logic kbd_access_in,
  // Frame start of the panel timing generator
  input wire logic panel_vsync_start_in,
  // Straps
  input wire logic [15:0] capture_data_straps_in,
  input wire logic capture_vsync_strap_in,
  input wire logic [11:0] gpio_straps_in,
  // Clock, memory and host gating
  output logic video_clock_en_out,
  output logic mem_clock_en_out,
  output logic dac_power_en_out,
  output logic display_blank_out,
  output logic host_mem_access_en_out,
  output logic host_io_access_en_out,
  output logic refresh_en_out,
  output logic mem_seq_restrict_out,
  // Monitor syncs
  output logic hsync_en_out,
  output logic vsync_en_out,
  // Panel power
  output logic panel_logic_power_enable_out,
  output logic panel_if_active_out,
  output logic panel_bias_power_enable_out,
  output logic backlight_enable_out,
  // State
  output logic [2:0] power_state_out
);
  // Pin synchronisers: a change counts once stages two and three agree
  logic [dpm_pkg::PIN_N-1:0] pin_raw;
  logic [dpm_pkg::PIN_N-1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q;
  assign pin_raw = {activity_pin_in, suspend_pin_in, standby_pin_in};

  genvar gi;
  generate
    for (gi = 0; gi < dpm_pkg::PIN_N; gi++) begin : g_pin
      always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          pin_s1_q[gi] <= 1'b0;
          pin_s2_q[gi] <= 1'b0;
          pin_s3_q[gi] <= 1'b0;
          pin_f_q[gi] <= 1'b0;
        end else begin
          pin_s1_q[gi] <= pin_raw[gi];
          pin_s2_q[gi] <= pin_s1_q[gi];
          pin_s3_q[gi] <= pin_s2_q[gi];
          if (pin_s2_q[gi] == pin_s3_q[gi]) begin
            pin_f_q[gi] <= pin_s3_q[gi];
          end
        end
      end
    end
  endgenerate

  // Registers
  logic [dpm_pkg::CTRL_W-1:0] ctrl_q;
  logic [7:0] timer_q;
  logic [28:0] strap_q;
  logic strap_taken_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic act_pin_prev_q;
  dpm_pkg::dpm_state_t state_q, state_d;

  // Bus decode
  logic setup_ph, access_ph, wr_take;
  logic hit_ctrl, hit_timer, hit_status, hit_strap, hit_any;
  logic host_down;
  logic wr_ctrl, wr_ctrl_pin_only, wr_timer;
  logic [31:0] rd_mux, status_word;
  assign setup_ph = psel_in && !penable_in;
  assign access_ph = psel_in && penable_in;
  assign hit_ctrl = (paddr_in == dpm_pkg::CTRL_OFF);
  assign hit_timer = (paddr_in == dpm_pkg::TIMER_OFF);
  assign hit_status = (paddr_in == dpm_pkg::STATUS_OFF);
  assign hit_strap = (paddr_in == dpm_pkg::STRAP_OFF);
  assign hit_any = hit_ctrl || hit_timer || hit_status || hit_strap;
  assign host_down = (state_q == dpm_pkg::DPM_HW_SUSPEND);
  assign wr_take = access_ph && pwrite_in;
  // Register-caused suspend leaves the host interface alive
  assign wr_ctrl = wr_take && hit_ctrl && !host_down;
  // With the host interface down only the pin-enable clear gets through
  assign wr_ctrl_pin_only = wr_take && hit_ctrl && host_down;
  assign wr_timer = wr_take && hit_timer && !host_down;

  // Control fields
  logic stby_sw, susp_sw, stby_pin_en, susp_pin_en, stby_tmr_en, dpms_tmr_en;
  logic dual_disp, bklt_pol, dac_dis, off_req;
  logic [2:0] act_sel;
  logic [3:0] period;
  assign stby_sw = ctrl_q[dpm_pkg::STBY_SW_BIT];
  assign susp_sw = ctrl_q[dpm_pkg::SUSP_SW_BIT];
  assign stby_pin_en = ctrl_q[dpm_pkg::STBY_PIN_EN_BIT];
  assign susp_pin_en = ctrl_q[dpm_pkg::SUSP_PIN_EN_BIT];
  assign stby_tmr_en = ctrl_q[dpm_pkg::STBY_TMR_EN_BIT];
  assign dpms_tmr_en = ctrl_q[dpm_pkg::DPMS_TMR_EN_BIT];
  assign dual_disp = ctrl_q[dpm_pkg::DUAL_DISP_BIT];
  assign bklt_pol = ctrl_q[dpm_pkg::BKLT_POL_BIT];
  assign dac_dis = ctrl_q[dpm_pkg::DAC_DIS_BIT];
  assign off_req = ctrl_q[dpm_pkg::OFF_REQ_BIT];
  assign act_sel = timer_q[dpm_pkg::TSEL_LSB +: 3];
  assign period = timer_q[dpm_pkg::TPER_LSB +: 4];

  // Activity: pin edges, memory and keyboard events, per the select mask
  logic act_pin_edge, activity;
  logic timeout;
  assign act_pin_edge = pin_f_q[dpm_pkg::PIN_ACT] ^ act_pin_prev_q;
  assign activity = (act_sel[0] && act_pin_edge) || (act_sel[1] && mem_access_in)
                    || (act_sel[2] && kbd_access_in);

  dpm_inact_timer #(
    .HALF_MIN_CYCLES(HALF_MIN_CYCLES)
  ) u_timer (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .monitor_none_in(act_sel == 3'h0),
    .activity_in(activity),
    .act_clears_in(stby_tmr_en || dpms_tmr_en),
    .period_in(period),
    .timeout_out(timeout)
  );

  // Power state sources
  logic susp_pin_act, stby_src, tmr_stby;
  assign susp_pin_act = susp_pin_en && pin_f_q[dpm_pkg::PIN_SUSP];
  assign tmr_stby = stby_tmr_en && timeout;
  assign stby_src = stby_sw || (stby_pin_en && pin_f_q[dpm_pkg::PIN_STBY]) || tmr_stby;

  // Timer-driven monitor saving enters standby on the same time-out
  logic dpms_tmr_act;
  assign dpms_tmr_act = dpms_tmr_en && timeout;

  always_comb begin
    if (off_req) begin
      state_d = dpm_pkg::DPM_OFF;
    end else if (susp_pin_act) begin
      state_d = dpm_pkg::DPM_HW_SUSPEND;
    end else if (susp_sw) begin
      state_d = dpm_pkg::DPM_SW_SUSPEND;
    end else if (stby_src || dpms_tmr_act) begin
      state_d = dpm_pkg::DPM_STANDBY;
    end else begin
      state_d = dpm_pkg::DPM_READY;
    end
  end

  // Control and timer writes; the strap image is taken once after reset
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_q <= dpm_pkg::CTRL_RESET;
      timer_q <= dpm_pkg::TIMER_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= pwdata_in[dpm_pkg::CTRL_W-1:0];
      end else if (wr_ctrl_pin_only && !pwdata_in[dpm_pkg::SUSP_PIN_EN_BIT]) begin
        ctrl_q[dpm_pkg::SUSP_PIN_EN_BIT] <= 1'b0;
      end
      if (wr_timer) begin
        timer_q <= pwdata_in[7:0];
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      strap_q <= dpm_pkg::STRAP_RESET;
      strap_taken_q <= 1'b0;
    end else if (!strap_taken_q) begin
      // First edge after release stands for the reset's rising edge
      strap_q <= {gpio_straps_in, capture_vsync_strap_in, capture_data_straps_in};
      strap_taken_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= dpm_pkg::DPM_READY;
      act_pin_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      act_pin_prev_q <= pin_f_q[dpm_pkg::PIN_ACT];
    end
  end

  // Panel sequencing: powered only in ready
  logic pnl_vdd, pnl_if, pnl_bias, pnl_bklt, pnl_busy;
  dpm_panel_seq u_panel (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .power_req_in(state_q == dpm_pkg::DPM_READY),
    .frame_start_in(panel_vsync_start_in),
    .logic_pwr_out(pnl_vdd),
    .if_active_out(pnl_if),
    .bias_pwr_out(pnl_bias),
    .bklt_out(pnl_bklt),
    .busy_out(pnl_busy)
  );

  // Status and read mux; the host interface answers nothing readable when down
  assign status_word = {25'h0, pin_f_q[dpm_pkg::PIN_SUSP], pnl_busy, pnl_vdd, timeout,
                        3'(state_q)};
  assign rd_mux = host_down ? 32'h0 :
                  hit_ctrl ? {22'h0, ctrl_q} :
                  hit_timer ? {24'h0, timer_q} :
                  hit_status ? status_word :
                  hit_strap ? {3'h0, strap_q} : 32'h0;

  // Read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end else if (setup_ph) begin
      prdata_q <= pwrite_in ? 32'h0 : rd_mux;
      pslverr_q <= !hit_any;
    end
  end

  assign prdata_out = prdata_q;
  assign pready_out = 1'b1;
  assign pslverr_out = access_ph && pslverr_q;

  // Per-state gating
  logic st_ready, st_stby, st_sws, st_hws, st_off, st_susp;
  assign st_ready = (state_q == dpm_pkg::DPM_READY);
  assign st_stby = (state_q == dpm_pkg::DPM_STANDBY);
  assign st_sws = (state_q == dpm_pkg::DPM_SW_SUSPEND);
  assign st_hws = (state_q == dpm_pkg::DPM_HW_SUSPEND);
  assign st_off = (state_q == dpm_pkg::DPM_OFF);
  assign st_susp = st_sws || st_hws;

  assign video_clock_en_out = st_ready;
  assign mem_clock_en_out = st_ready || st_stby;
  assign dac_power_en_out = st_ready && !dac_dis;
  assign display_blank_out = !st_ready;
  assign host_mem_access_en_out = st_ready || st_stby;
  assign host_io_access_en_out = !(st_hws || st_off);
  assign refresh_en_out = !st_off;
  assign mem_seq_restrict_out = st_stby;

  // Monitor saving; dual display goes straight to full off
  logic dpms_all_off;
  assign dpms_all_off = st_off || (dual_disp && (st_stby || st_susp));
  assign hsync_en_out = !dpms_all_off && !st_stby;
  assign vsync_en_out = !dpms_all_off && !st_susp;

  assign panel_logic_power_enable_out = pnl_vdd;
  assign panel_if_active_out = pnl_if;
  assign panel_bias_power_enable_out = pnl_bias;
  assign backlight_enable_out = pnl_bklt ^ bklt_pol;
  assign power_state_out = 3'(state_q);
endmodule
`default_nettype wire

// [design/dpm_pkg.sv]
package dpm_pkg;
  // System clock and time bases
  localparam longint unsigned CLK_HZ = 64'd125_000_000;
  localparam longint unsigned HALF_MIN_S = 64'd30;
  localparam logic [31:0] HALF_MIN_CYCLES = 32'(CLK_HZ * HALF_MIN_S);
  // Panel sequence waits, in vertical periods
  localparam logic [2:0] UP_IF_FRAMES = 3'h1;
  localparam logic [2:0] UP_BIAS_FRAMES = 3'h3;
  localparam logic [2:0] UP_BKLT_FRAMES = 3'h1;
  localparam logic [2:0] DN_BIAS_FRAMES = 3'h1;
  localparam logic [2:0] DN_IF_FRAMES = 3'h3;
  localparam logic [2:0] DN_VDD_FRAMES = 3'h1;
  // Register byte addresses
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] TIMER_OFF = 8'h04;
  localparam logic [7:0] STATUS_OFF = 8'h08;
  localparam logic [7:0] STRAP_OFF = 8'h0C;
  // Control register fields
  localparam int STBY_SW_BIT = 0;
  localparam int SUSP_SW_BIT = 1;
  localparam int STBY_PIN_EN_BIT = 2;
  localparam int SUSP_PIN_EN_BIT = 3;
  localparam int STBY_TMR_EN_BIT = 4;
  localparam int DPMS_TMR_EN_BIT = 5;
  localparam int DUAL_DISP_BIT = 6;
  localparam int BKLT_POL_BIT = 7;
  localparam int DAC_DIS_BIT = 8;
  localparam int OFF_REQ_BIT = 9;
  localparam int CTRL_W = 10;
  localparam logic [9:0] CTRL_RESET = 10'h000;
  // Timer register fields
  localparam int TSEL_LSB = 0;
  localparam int TPER_LSB = 4;
  localparam logic [7:0] TIMER_RESET = 8'h00;
  // Status register fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_TIMEOUT_BIT = 3;
  localparam int ST_PANEL_ON_BIT = 4;
  localparam int ST_PANEL_BUSY_BIT = 5;
  localparam int ST_PIN_SUSP_BIT = 6;
  // Strap register fields
  localparam int SP_CAP_VSYNC_BIT = 16;
  localparam int SP_GPIO_LSB = 17;
  localparam logic [28:0] STRAP_RESET = 29'h0;
  // Pin synchroniser lanes
  localparam int PIN_STBY = 0;
  localparam int PIN_SUSP = 1;
  localparam int PIN_ACT = 2;
  localparam int PIN_N = 3;
  localparam logic [2:0] PIN_RESET = 3'h0;

  typedef enum logic [2:0] {
    DPM_READY, DPM_STANDBY, DPM_SW_SUSPEND, DPM_HW_SUSPEND, DPM_OFF
  } dpm_state_t;

  typedef enum logic [2:0] {
    PSQ_OFF, PSQ_UP_IF, PSQ_UP_BIAS, PSQ_UP_BKLT, PSQ_ON, PSQ_DN_BIAS, PSQ_DN_IF, PSQ_DN_VDD
  } dpm_pseq_t;
endpackage

// [design/dpm_panel_seq.sv]
`timescale 1ns/1ps
`default_nettype none
module dpm_panel_seq (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // Control
  input wire logic power_req_in,
  input wire logic frame_start_in,
  // Panel controls, active high
  output logic logic_pwr_out,
  output logic if_active_out,
  output logic bias_pwr_out,
  output logic bklt_out,
  output logic busy_out
);
  dpm_pkg::dpm_pseq_t state_q, state_d;
  logic [2:0] frames_q, frames_d;
  logic aligned_q, aligned_d;
  logic [2:0] wait_need;
  logic wait_done;

  // The first frame start only aligns, so every wait is whole frames
  assign wait_done = frame_start_in && aligned_q && (frames_q + 3'h1 == wait_need);

  always_comb begin
    unique case (state_q)
      dpm_pkg::PSQ_UP_IF: wait_need = dpm_pkg::UP_IF_FRAMES;
      dpm_pkg::PSQ_UP_BIAS: wait_need = dpm_pkg::UP_BIAS_FRAMES;
      dpm_pkg::PSQ_UP_BKLT: wait_need = dpm_pkg::UP_BKLT_FRAMES;
      dpm_pkg::PSQ_DN_BIAS: wait_need = dpm_pkg::DN_BIAS_FRAMES;
      dpm_pkg::PSQ_DN_IF: wait_need = dpm_pkg::DN_IF_FRAMES;
      dpm_pkg::PSQ_DN_VDD: wait_need = dpm_pkg::DN_VDD_FRAMES;
      default: wait_need = 3'h1;
    endcase
  end

  always_comb begin
    state_d = state_q;
    frames_d = frames_q;
    aligned_d = aligned_q;
    if (frame_start_in) begin
      aligned_d = 1'b1;
      if (aligned_q) begin
        frames_d = frames_q + 3'h1;
      end
    end
    if (wait_done || state_q == dpm_pkg::PSQ_OFF || state_q == dpm_pkg::PSQ_ON) begin
      frames_d = 3'h0;
      aligned_d = 1'b0;
    end
    unique case (state_q)
      dpm_pkg::PSQ_OFF: if (power_req_in) state_d = dpm_pkg::PSQ_UP_IF;
      dpm_pkg::PSQ_UP_IF: if (wait_done) state_d = dpm_pkg::PSQ_UP_BIAS;
      dpm_pkg::PSQ_UP_BIAS: if (wait_done) state_d = dpm_pkg::PSQ_UP_BKLT;
      dpm_pkg::PSQ_UP_BKLT: if (wait_done) state_d = dpm_pkg::PSQ_ON;
      dpm_pkg::PSQ_ON: if (!power_req_in) state_d = dpm_pkg::PSQ_DN_BIAS;
      dpm_pkg::PSQ_DN_BIAS: if (wait_done) state_d = dpm_pkg::PSQ_DN_IF;
      dpm_pkg::PSQ_DN_IF: if (wait_done) state_d = dpm_pkg::PSQ_DN_VDD;
      dpm_pkg::PSQ_DN_VDD: if (wait_done) state_d = dpm_pkg::PSQ_OFF;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= dpm_pkg::PSQ_OFF;
      frames_q <= 3'h0;
      aligned_q <= 1'b0;
    end else begin
      state_q <= state_d;
      frames_q <= frames_d;
      aligned_q <= aligned_d;
    end
  end

  // Each step is reached only through the previous one
  assign logic_pwr_out = (state_q != dpm_pkg::PSQ_OFF);
  assign if_active_out = (state_q inside {dpm_pkg::PSQ_UP_BIAS, dpm_pkg::PSQ_UP_BKLT,
                         dpm_pkg::PSQ_ON, dpm_pkg::PSQ_DN_BIAS, dpm_pkg::PSQ_DN_IF});
  assign bias_pwr_out = (state_q inside {dpm_pkg::PSQ_UP_BKLT, dpm_pkg::PSQ_ON,
                        dpm_pkg::PSQ_DN_BIAS});
  assign bklt_out = (state_q == dpm_pkg::PSQ_ON);
  assign busy_out = !(state_q inside {dpm_pkg::PSQ_OFF, dpm_pkg::PSQ_ON});
endmodule
`default_nettype wire

// [design/dpm_inact_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module dpm_inact_timer #(
  parameter logic [31:0] HALF_MIN_CYCLES = dpm_pkg::HALF_MIN_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // Control
  input wire logic monitor_none_in,
  input wire logic activity_in,
  input wire logic act_clears_in,
  input wire logic [3:0] period_in,
  // Status
  output logic timeout_out
);
  logic [31:0] presc_q;
  logic [4:0] halves_q;
  logic timeout_q;
  logic half_tick;
  logic [4:0] halves_need;
  logic expire;

  // Period 0 is half a minute, n is n minutes
  assign halves_need = (period_in == 4'h0) ? 5'h01 : {period_in, 1'b0};
  assign half_tick = (presc_q == HALF_MIN_CYCLES - 32'h1);
  assign expire = half_tick && (halves_q + 5'h01 == halves_need) && !timeout_q;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      presc_q <= 32'h0;
      halves_q <= 5'h00;
      timeout_q <= 1'b0;
    end else if (monitor_none_in) begin
      presc_q <= 32'h0;
      halves_q <= 5'h00;
      timeout_q <= 1'b0;
    end else if (activity_in) begin
      presc_q <= 32'h0;
      halves_q <= 5'h00;
      timeout_q <= timeout_q && !act_clears_in;
    end else if (!timeout_q) begin
      presc_q <= half_tick ? 32'h0 : presc_q + 32'h1;
      halves_q <= half_tick ? halves_q + 5'h01 : halves_q;
      timeout_q <= expire;
    end
  end

  assign timeout_out = timeout_q;
endmodule
`default_nettype wire

// [testbench/dpm_panel_timing_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dpm_panel_timing_model #(
  parameter int FRAME = 40
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // Frame start pulse
  output logic frame_start_out
);
  // Free running, so panel waits may start anywhere inside a frame
  int cnt_q;
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_q <= 0;
      frame_start_out <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == FRAME - 1) ? 0 : cnt_q + 1;
      frame_start_out <= (cnt_q == FRAME - 1);
    end
  end
endmodule
`default_nettype wire

// [testbench/dpm_power_manager_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module dpm_power_manager_checker (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // Gating and state
  input wire logic video_clock_en_out,
  input wire logic mem_clock_en_out,
  input wire logic dac_power_en_out,
  input wire logic display_blank_out,
  input wire logic host_mem_access_en_out,
  input wire logic host_io_access_en_out,
  input wire logic refresh_en_out,
  input wire logic mem_seq_restrict_out,
  input wire logic [2:0] power_state_out,
  // Panel
  input wire logic panel_logic_power_enable_out,
  input wire logic panel_if_active_out,
  input wire logic panel_bias_power_enable_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  stby_gate_a: assert property (power_state_out == 3'h1 |->
    !video_clock_en_out && display_blank_out && !dac_power_en_out) else $error("standby gating");
  stby_host_a: assert property (power_state_out == 3'h1 |-> mem_seq_restrict_out &&
    host_mem_access_en_out && host_io_access_en_out && refresh_en_out) else $error("standby host");
  susp_gate_a: assert property (power_state_out inside {3'h2, 3'h3} |->
    !video_clock_en_out && !mem_clock_en_out && !host_mem_access_en_out && !dac_power_en_out)
    else $error("suspend gating");
  sw_susp_io_a: assert property (power_state_out == 3'h2 |->
    host_io_access_en_out && refresh_en_out) else $error("sw suspend io");
  hw_susp_io_a: assert property (power_state_out == 3'h3 |->
    !host_io_access_en_out && refresh_en_out) else $error("hw suspend io");
  off_all_a: assert property (power_state_out == 3'h4 |->
    !refresh_en_out && !host_io_access_en_out && !mem_clock_en_out) else $error("off gating");
  ready_all_a: assert property (power_state_out == 3'h0 |-> video_clock_en_out &&
    mem_clock_en_out && host_mem_access_en_out && !display_blank_out) else $error("ready gating");
  up_if_a: assert property ($rose(panel_if_active_out) |->
    panel_logic_power_enable_out && !panel_bias_power_enable_out) else $error("if up order");
  up_bias_a: assert property ($rose(panel_bias_power_enable_out) |->
    $past(panel_if_active_out, 2)) else $error("bias up order");
  dn_if_a: assert property ($fell(panel_if_active_out) |->
    !panel_bias_power_enable_out && panel_logic_power_enable_out) else $error("if down order");
  dn_vdd_a: assert property ($fell(panel_logic_power_enable_out) |->
    !panel_if_active_out) else $error("vdd down order");
endmodule
bind dpm_power_manager dpm_power_manager_checker u_chk (.clk_sys_in, .arst_n_in,
  .video_clock_en_out, .mem_clock_en_out, .dac_power_en_out, .display_blank_out,
  .host_mem_access_en_out, .host_io_access_en_out, .refresh_en_out, .mem_seq_restrict_out,
  .power_state_out, .panel_logic_power_enable_out, .panel_if_active_out,
  .panel_bias_power_enable_out);
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int FR = 40;
  logic clk_sys_in, arst_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, err;
  logic [7:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, q;
  logic standby_pin_in, suspend_pin_in, activity_pin_in, mem_access_in, kbd_access_in;
  logic panel_vsync_start_in, capture_vsync_strap_in, hsync_en_out, vsync_en_out;
  logic [15:0] capture_data_straps_in;
  logic [11:0] gpio_straps_in;
  logic video_clock_en_out, mem_clock_en_out, dac_power_en_out, display_blank_out;
  logic host_mem_access_en_out, host_io_access_en_out, refresh_en_out, mem_seq_restrict_out;
  logic panel_logic_power_enable_out, panel_if_active_out, panel_bias_power_enable_out;
  logic backlight_enable_out;
  logic [2:0] power_state_out;
  logic [3:0] pan, pan_p;
  int n_fail, total_checks, cyc, t_up[4], t_dn[4];
  // Short half minute keeps the timer scenarios within a few hundred cycles
  dpm_power_manager #(.HALF_MIN_CYCLES(32'h0000_000A)) u_dut (.clk_sys_in, .arst_n_in,
    .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
    .pslverr_out, .standby_pin_in, .suspend_pin_in, .activity_pin_in, .mem_access_in,
    .kbd_access_in, .panel_vsync_start_in, .capture_data_straps_in, .capture_vsync_strap_in,
    .gpio_straps_in, .video_clock_en_out, .mem_clock_en_out, .dac_power_en_out,
    .display_blank_out, .host_mem_access_en_out, .host_io_access_en_out, .refresh_en_out,
    .mem_seq_restrict_out, .hsync_en_out, .vsync_en_out, .panel_logic_power_enable_out,
    .panel_if_active_out, .panel_bias_power_enable_out, .backlight_enable_out,
    .power_state_out);
  dpm_panel_timing_model #(.FRAME(FR)) u_pnl (.clk_sys_in, .arst_n_in,
    .frame_start_out(panel_vsync_start_in));
  assign pan = {backlight_enable_out, panel_bias_power_enable_out, panel_if_active_out,
    panel_logic_power_enable_out};
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    pan_p <= pan;
    for (int i = 0; i < 4; i++) begin
      if (pan[i] && !pan_p[i]) t_up[i] <= cyc;
      if (!pan[i] && pan_p[i]) t_dn[i] <= cyc;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    do @(posedge clk_sys_in); while (pready_out !== 1'b1);
    q = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e, m);
    apb(1'b0, a, 32'h0);
    chk(nm, e & m, q & m);
  endtask
  task automatic wait_st(input logic [2:0] s);
    for (int i = 0; i < 20 && power_state_out !== s; i++) @(posedge clk_sys_in);
    chk("state", {29'h0, s}, {29'h0, power_state_out});
  endtask
  task automatic gap(input string nm, input int d, input int n);
    chk(nm, 32'h1, {31'h0, d >= n * FR && d <= (n + 1) * FR});
  endtask
  task automatic sync(input logic [2:0] e);
    chk("hs vs dac", {29'h0, e}, {29'h0, hsync_en_out, vsync_en_out, dac_power_en_out});
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    #100_000;
    n_fail++;
    test_done;
  end
  initial begin
    arst_n_in = 1'b0;
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
    {standby_pin_in, suspend_pin_in, activity_pin_in, mem_access_in, kbd_access_in} = '0;
    {capture_data_straps_in, capture_vsync_strap_in, gpio_straps_in} = {16'hA5C3, 1'b1, 12'h9B6};
    repeat (10) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    {capture_data_straps_in, capture_vsync_strap_in, gpio_straps_in} <= '0;
    rd("strap", 8'h0C, 32'h136D_A5C3, '1);
    rd("ctrl", 8'h00, 32'h0, '1);
    apb(1'b1, 8'h00, 32'h140);
    rd("ctrl", 8'h00, 32'h140, '1);
    apb(1'b1, 8'h04, 32'hF7);
    rd("timer", 8'h04, 32'hF7, '1);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    for (int i = 0; i < 12 * FR && !backlight_enable_out; i++) @(posedge clk_sys_in);
    @(posedge clk_sys_in);
    gap("if up", t_up[1] - t_up[0], 1);
    gap("bias up", t_up[2] - t_up[1], 3);
    gap("bklt up", t_up[3] - t_up[2], 1);
    sync(3'h7);
    apb(1'b1, 8'h00, 32'h80);
    @(posedge clk_sys_in);
    chk("bklt pol", 32'h0, {31'h0, backlight_enable_out});
    apb(1'b1, 8'h00, 32'h1);
    wait_st(3'h1);
    sync(3'h2);
    for (int i = 0; i < 12 * FR && panel_logic_power_enable_out; i++) @(posedge clk_sys_in);
    @(posedge clk_sys_in);
    gap("bias dn", t_dn[2] - t_dn[3], 1);
    gap("if dn", t_dn[1] - t_dn[2], 3);
    gap("vdd dn", t_dn[0] - t_dn[1], 1);
    apb(1'b1, 8'h00, 32'h5);
    standby_pin_in <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    apb(1'b1, 8'h00, 32'h4);
    repeat (8) @(posedge clk_sys_in);
    chk("pin stby", 32'h1, {29'h0, power_state_out});
    standby_pin_in <= 1'b0;
    wait_st(3'h0);
    apb(1'b1, 8'h00, 32'h41);
    wait_st(3'h1);
    sync(3'h0);
    apb(1'b1, 8'h00, 32'h2);
    wait_st(3'h2);
    sync(3'h4);
    rd("ctrl", 8'h00, 32'h2, '1);
    apb(1'b1, 8'h00, 32'h8);
    wait_st(3'h0);
    suspend_pin_in <= 1'b1;
    wait_st(3'h3);
    rd("host off", 8'h04, 32'h0, '1);
    suspend_pin_in <= 1'b0;
    repeat (7) @(posedge clk_sys_in);
    chk("pin release", 32'h0, {29'h0, power_state_out});
    suspend_pin_in <= 1'b1;
    wait_st(3'h3);
    apb(1'b1, 8'h00, 32'h0);
    wait_st(3'h0);
    suspend_pin_in <= 1'b0;
    apb(1'b1, 8'h00, 32'h200);
    wait_st(3'h4);
    sync(3'h0);
    // Timer left at F7 has long timed out; select none clears it
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h00, 32'h10);
    apb(1'b1, 8'h04, 32'h12);
    repeat (8) @(posedge clk_sys_in);
    rd("timeout", 8'h08, 32'h0, 32'hF);
    repeat (20) @(posedge clk_sys_in);
    rd("timeout", 8'h08, 32'h9, 32'hF);
    kbd_access_in <= 1'b1;
    @(posedge clk_sys_in);
    kbd_access_in <= 1'b0;
    rd("kbd", 8'h08, 32'h9, 32'hF);
    mem_access_in <= 1'b1;
    @(posedge clk_sys_in);
    mem_access_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rd("activity", 8'h08, 32'h0, 32'hF);
    repeat (25) @(posedge clk_sys_in);
    rd("timeout", 8'h08, 32'h8, 32'h8);
    apb(1'b1, 8'h04, 32'h10);
    rd("select none", 8'h08, 32'h0, 32'h8);
    test_done;
  end
endmodule
`default_nettype wire
